//--- logic/ofc_pkg.sv
`default_nettype none
package ofc_pkg;
    // ************************************************************
    // Register addresses
    // ************************************************************
    localparam logic [15:0] OFC_ADDR_EXEC = 16'ha0cf;
    localparam logic [15:0] OFC_ADDR_PW_HI = 16'ha0d0;
    localparam logic [15:0] OFC_ADDR_PW_LO = 16'ha0d1;
    localparam logic [15:0] OFC_ADDR_SPARE = 16'ha0d2;
    localparam logic [15:0] OFC_ADDR_CHG = 16'ha0d3;
    localparam logic [15:0] OFC_ADDR_NRM = 16'ha0d4;
    localparam logic [15:0] OFC_ADDR_FST = 16'ha0d5;
    // ************************************************************
    // Values and fields
    // ************************************************************
    localparam logic [15:0] OFC_EXEC_GO = 16'h0001;
    localparam logic [15:0] OFC_RST_WORD = 16'h0000;
    localparam logic [15:0] OFC_DEF_PW = 16'h2020;
    localparam int OFC_NPT = 8;
    localparam logic [15:0] OFC_USED_MASK = 16'h00ff;
    localparam logic [7:0] OFC_RST_PT = 8'h00;
    // Modbus answer codes
    localparam logic [7:0] OFC_FC_PRESET = 8'h10;
    localparam logic [7:0] OFC_EXC_ADDR = 8'h02;
endpackage
`default_nettype wire

//--- logic/ofc_output_force_control.sv
`timescale 1ns/1ps
`default_nettype none
module ofc_output_force_control
    import ofc_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Holding register access from the Modbus engine
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic frame_end,
    output logic [15:0] reg_rdata,
    output logic reg_rvalid,
    output logic rsp_valid,
    output logic rsp_ok,
    output logic [7:0] rsp_code,
    // Active password from settings
    input wire logic [15:0] active_pw_hi,
    input wire logic [15:0] active_pw_lo,
    // Non-volatile store image
    input wire logic nv_load,
    input wire logic [7:0] nv_forced_in,
    input wire logic [7:0] nv_value_in,
    output logic nv_save,
    output logic [7:0] nv_forced_out,
    output logic [7:0] nv_value_out,
    // Relay outputs
    input wire logic [7:0] term_state,
    input wire logic [7:0] logic_drive,
    output logic [7:0] relay_drive,
    output logic [7:0] point_status,
    output logic [7:0] point_forced
);
    // ************************************************************
    // Staging registers
    // ************************************************************
    logic [15:0] pw_hi_ff, nxt_pw_hi;
    logic [15:0] pw_lo_ff, nxt_pw_lo;
    logic [15:0] chg_ff, nxt_chg;
    logic [15:0] nrm_ff, nxt_nrm;
    logic [15:0] fst_ff, nxt_fst;
    logic [15:0] exec_ff, nxt_exec;
    logic [7:0] frc_ff, nxt_frc;
    logic [7:0] val_ff, nxt_val;
    logic [15:0] rdata_ff, nxt_rdata;
    logic rvalid_ff, nxt_rvalid;
    logic save_ff, nxt_save;
    logic bad_ff, nxt_bad;
    logic rsp_ff, nxt_rsp;
    logic ok_ff, nxt_ok;
    logic [7:0] code_ff, nxt_code;
    logic hit, go, pw_ok;

    // ************************************************************
    // Address decode and execute qualification
    // ************************************************************
    // Whole control block, spare word included
    assign hit = (reg_addr >= OFC_ADDR_EXEC) && (reg_addr <= OFC_ADDR_FST);
    // Password words staged by earlier writes
    assign pw_ok = (pw_hi_ff == active_pw_hi) && (pw_lo_ff == active_pw_lo);
    // Only the exact go word acts; other values are just stored
    // execute word decode
    assign go = reg_wr && (reg_addr == OFC_ADDR_EXEC) && (reg_wdata == OFC_EXEC_GO);

    // ************************************************************
    // Register writes and force update
    // ************************************************************
    always_comb begin
        nxt_pw_hi = pw_hi_ff;
        nxt_pw_lo = pw_lo_ff;
        nxt_chg = chg_ff;
        nxt_nrm = nrm_ff;
        nxt_fst = fst_ff;
        nxt_exec = exec_ff;
        nxt_frc = frc_ff;
        nxt_val = val_ff;
        nxt_save = 1'b0;
        nxt_bad = bad_ff;
        if (reg_wr) begin
            if (reg_addr == OFC_ADDR_EXEC) begin
                nxt_exec = reg_wdata;
            end else if (reg_addr == OFC_ADDR_PW_HI) begin
                nxt_pw_hi = reg_wdata;
            end else if (reg_addr == OFC_ADDR_PW_LO) begin
                nxt_pw_lo = reg_wdata;
            end else if (reg_addr == OFC_ADDR_CHG) begin
                nxt_chg = reg_wdata & OFC_USED_MASK;
            end else if (reg_addr == OFC_ADDR_NRM) begin
                nxt_nrm = reg_wdata & OFC_USED_MASK;
            end else if (reg_addr == OFC_ADDR_FST) begin
                nxt_fst = reg_wdata & OFC_USED_MASK;
            end else if (reg_addr != OFC_ADDR_SPARE) begin
                nxt_bad = 1'b1;
            end
        end
        if (reg_rd && !hit) begin
            nxt_bad = 1'b1;
        end
        // Fresh frame; a fault in this cycle goes into the answer
        if (frame_end) begin
            nxt_bad = 1'b0;
        end
        // Store image wins over an execute in the same cycle
        // reload from non-volatile image
        if (nv_load) begin
            nxt_frc = nv_forced_in;
            nxt_val = nv_value_in;
        end else if (go && pw_ok) begin
            nxt_frc = (frc_ff & ~chg_ff[7:0]) | (chg_ff[7:0] & nrm_ff[7:0]);
            nxt_val = (val_ff & ~chg_ff[7:0]) | (chg_ff[7:0] & nrm_ff[7:0] & fst_ff[7:0]);
            nxt_save = 1'b1;
        end
    end

    // ************************************************************
    // Read port and command answer
    // ************************************************************
    always_comb begin
        nxt_rdata = rdata_ff;
        nxt_rvalid = reg_rd;
        nxt_rsp = frame_end;
        nxt_ok = ok_ff;
        nxt_code = code_ff;
        if (reg_rd) begin
            if (reg_addr == OFC_ADDR_EXEC) begin
                nxt_rdata = exec_ff;
            end else if (reg_addr == OFC_ADDR_PW_HI) begin
                nxt_rdata = pw_hi_ff;
            end else if (reg_addr == OFC_ADDR_PW_LO) begin
                nxt_rdata = pw_lo_ff;
            end else if (reg_addr == OFC_ADDR_CHG) begin
                nxt_rdata = chg_ff;
            end else if (reg_addr == OFC_ADDR_NRM) begin
                nxt_rdata = nrm_ff;
            end else if (reg_addr == OFC_ADDR_FST) begin
                nxt_rdata = fst_ff;
            end else begin
                nxt_rdata = OFC_RST_WORD;
            end
        end
        if (frame_end) begin
            nxt_ok = !(bad_ff || (reg_wr && !hit) || (reg_rd && !hit));
            nxt_code = nxt_ok ? OFC_FC_PRESET : OFC_EXC_ADDR;
        end
    end

    // ************************************************************
    // Register stages
    // ************************************************************
    // Staging words and force state
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pw_hi_ff <= OFC_RST_WORD;
            pw_lo_ff <= OFC_RST_WORD;
            chg_ff <= OFC_RST_WORD;
            nrm_ff <= OFC_RST_WORD;
            fst_ff <= OFC_RST_WORD;
            exec_ff <= OFC_RST_WORD;
            frc_ff <= OFC_RST_PT;
            val_ff <= OFC_RST_PT;
            save_ff <= 1'b0;
            bad_ff <= 1'b0;
        end else begin
            pw_hi_ff <= nxt_pw_hi;
            pw_lo_ff <= nxt_pw_lo;
            chg_ff <= nxt_chg;
            nrm_ff <= nxt_nrm;
            fst_ff <= nxt_fst;
            exec_ff <= nxt_exec;
            frc_ff <= nxt_frc;
            val_ff <= nxt_val;
            save_ff <= nxt_save;
            bad_ff <= nxt_bad;
        end
    end

    // Read data and command answer
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rdata_ff <= OFC_RST_WORD;
            rvalid_ff <= 1'b0;
            rsp_ff <= 1'b0;
            ok_ff <= 1'b0;
            code_ff <= OFC_RST_PT;
        end else begin
            rdata_ff <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
            rsp_ff <= nxt_rsp;
            ok_ff <= nxt_ok;
            code_ff <= nxt_code;
        end
    end

    // ************************************************************
    // Per-point output selection
    // ************************************************************
    for (genvar i = 0; i < OFC_NPT; i++) begin : g_pt
        // Forced points hide the terminal from the status
        // forced value or normal path
        assign relay_drive[i] = frc_ff[i] ? val_ff[i] : logic_drive[i];
        assign point_status[i] = frc_ff[i] ? val_ff[i] : term_state[i];
    end

    // ************************************************************
    // Output ports
    // ************************************************************
    assign point_forced = frc_ff;
    assign nv_save = save_ff;
    assign nv_forced_out = frc_ff;
    assign nv_value_out = val_ff;
    assign reg_rdata = rdata_ff;
    assign reg_rvalid = rvalid_ff;
    assign rsp_valid = rsp_ff;
    assign rsp_ok = ok_ff;
    assign rsp_code = code_ff;
endmodule
`default_nettype wire

//--- verification/ofc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module ofc_host_model
    import ofc_pkg::*;
(
    // Clock and answers
    input wire logic sys_clk,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rvalid,
    // Requests
    output logic reg_wr,
    output logic reg_rd,
    output logic frame_end,
    output logic [15:0] reg_addr,
    output logic [15:0] reg_wdata
);
    // Idle bus at time zero
    initial {reg_wr, reg_rd, frame_end, reg_addr, reg_wdata} = '0;
    // One word per strobe, held over one rising edge
    task automatic word(input logic [15:0] a, input logic [15:0] d, input logic last);
        @(negedge sys_clk);
        {reg_wr, reg_rd, reg_addr, reg_wdata, frame_end} = {2'b10, a, d, last};
    endtask
    // Strobes drop to zero; address and data lines show the inverse of their last value
    task automatic idle();
        @(negedge sys_clk);
        {reg_wr, reg_rd, frame_end} = '0;
        {reg_addr, reg_wdata} = ~{reg_addr, reg_wdata};
    endtask
    task automatic block(input logic [15:0] pw, input logic [15:0] c, input logic [15:0] n, input logic [15:0] f);
        word(OFC_ADDR_PW_HI, pw, 1'b0);
        word(OFC_ADDR_PW_LO, pw, 1'b0);
        word(OFC_ADDR_SPARE, 16'h0000, 1'b0);
        word(OFC_ADDR_CHG, c, 1'b0);
        word(OFC_ADDR_NRM, n, 1'b0);
        word(OFC_ADDR_FST, f, 1'b0);
        word(OFC_ADDR_EXEC, OFC_EXEC_GO, 1'b1);
        idle();
    endtask
    task automatic rd(input logic [15:0] a, output logic [15:0] d, output logic ok);
        @(negedge sys_clk);
        {reg_rd, reg_addr} = {1'b1, a};
        ok = 1'b0;
        for (int i = 0; i < 4 && !ok; i++) begin
            @(negedge sys_clk);
            reg_rd = 1'b0;
            ok = (reg_rvalid === 1'b1);
            d = reg_rdata;
        end
    endtask
endmodule
`default_nettype wire

//--- verification/ofc_chk.sv
`timescale 1ns/1ps
`default_nettype none
module ofc_chk
    import ofc_pkg::*;
(
    // Clock, reset and requests
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic frame_end,
    input wire logic nv_load,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    // Answers and points
    input wire logic reg_rvalid,
    input wire logic rsp_valid,
    input wire logic nv_save,
    input wire logic [7:0] term_state,
    input wire logic [7:0] logic_drive,
    input wire logic [7:0] relay_drive,
    input wire logic [7:0] point_status,
    input wire logic [7:0] point_forced,
    input wire logic [7:0] nv_value_out,
    input wire logic [7:0] nv_forced_out
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // Execute write at the port
    logic exec_wr;
    assign exec_wr = reg_wr && (reg_addr == OFC_ADDR_EXEC);
    follow_status_a: assert property ((point_status & ~point_forced) == (term_state & ~point_forced))
        else $error("status not following terminal");
    follow_relay_a: assert property ((relay_drive & ~point_forced) == (logic_drive & ~point_forced))
        else $error("relay not following drive");
    forced_value_a: assert property ((relay_drive & point_forced) == (nv_value_out & point_forced))
        else $error("forced relay value wrong");
    forced_status_a: assert property ((point_status & point_forced) == (nv_value_out & point_forced))
        else $error("forced status value wrong");
    nv_mirror_a: assert property (nv_forced_out == point_forced)
        else $error("stored forced flags differ");
    force_hold_a: assert property (!exec_wr && !nv_load |=> $stable(point_forced) && $stable(nv_value_out))
        else $error("forcing changed without execute");
    save_cause_a: assert property (nv_save |-> $past(exec_wr) && $past(reg_wdata) == OFC_EXEC_GO)
        else $error("save without execute");
    rsp_pulse_a: assert property (rsp_valid == $past(frame_end))
        else $error("response not one cycle after frame");
    read_pulse_a: assert property (reg_rvalid == $past(reg_rd))
        else $error("read answer misplaced");
    // Main scenarios
    cover property (nv_save);
    cover property (nv_load ##1 point_forced != 8'h00);
    cover property (exec_wr ##1 point_forced == 8'h00);
endmodule
bind ofc_output_force_control ofc_chk i_ofc_chk (.*);
`default_nettype wire

//--- verification/ofc_output_force_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module ofc_output_force_control_tb_top;
    import ofc_pkg::*;
    // Bench signals
    logic sys_clk = 1'b0, rstn = 1'b0, nv_load = 1'b0;
    logic reg_wr, reg_rd, frame_end, reg_rvalid, rsp_valid, rsp_ok, nv_save;
    logic [15:0] reg_addr, reg_wdata, reg_rdata, active_pw_hi = OFC_DEF_PW, active_pw_lo = OFC_DEF_PW;
    logic [7:0] rsp_code, nv_forced_in = 8'h84, nv_value_in = 8'h00, nv_forced_out, nv_value_out;
    logic [7:0] term_state = 8'h1a, logic_drive = 8'h25, relay_drive, point_status, point_forced;
    int n_fail = 0, compares = 0;
    always #2.5 sys_clk = ~sys_clk;
    ofc_output_force_control i_ofc_output_force_control (.*);
    ofc_host_model i_ofc_host_model (.*);
    // Compare and report
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rdc(input logic [15:0] a, input logic [15:0] exp);
        logic [15:0] d;
        logic ok;
        i_ofc_host_model.rd(a, d, ok);
        chk(ok ? d : ~exp, exp);
        // A read that never answers ends the run
        if (!ok) begin
            conclude();
        end
    endtask
    task automatic conclude();
        $display("compares %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Hang guard
    initial begin
        repeat (5000) @(posedge sys_clk);
        n_fail++;
        conclude();
    end
    // Test sequence
    initial begin
        repeat (6) @(negedge sys_clk);
        rstn = 1'b1;
        i_ofc_host_model.block(OFC_DEF_PW, 16'h0080, 16'h0080, 16'h0080);
        chk({relay_drive, point_status}, 16'ha59a);
        chk({nv_save, rsp_valid, rsp_ok, 5'h00, rsp_code}, 16'he010);
        $display("end of test: force on");
        {logic_drive, term_state} = 16'ha59a;
        i_ofc_host_model.block(OFC_DEF_PW, 16'h0080, 16'h0080, 16'h0000);
        chk({relay_drive, point_status}, 16'h251a);
        chk({nv_forced_out, nv_value_out}, 16'h8000);
        $display("end of test: force off");
        i_ofc_host_model.block(16'h1234, 16'h0080, 16'h0000, 16'h0000);
        chk({point_forced, relay_drive}, 16'h8025);
        chk({nv_save, rsp_valid, rsp_ok, 5'h00, rsp_code}, 16'h6010);
        i_ofc_host_model.word(OFC_ADDR_CHG, 16'hffff, 1'b1);
        i_ofc_host_model.idle();
        rdc(OFC_ADDR_CHG, 16'h00ff);
        rdc(OFC_ADDR_SPARE, 16'h0000);
        $display("end of test: refused and read back");
        i_ofc_host_model.block(OFC_DEF_PW, 16'h0080, 16'h0000, 16'h0000);
        chk({relay_drive, point_status}, 16'ha59a);
        chk({8'h00, point_forced}, 16'h0000);
        i_ofc_host_model.word(16'ha0d6, 16'h0000, 1'b1);
        i_ofc_host_model.idle();
        chk({rsp_valid, rsp_ok, 6'h00, rsp_code}, 16'h8002);
        $display("end of test: unforce and bad address");
        i_ofc_host_model.word(OFC_ADDR_CHG, 16'h0004, 1'b1);
        i_ofc_host_model.word(OFC_ADDR_NRM, 16'h0004, 1'b1);
        i_ofc_host_model.word(OFC_ADDR_FST, 16'h0004, 1'b1);
        i_ofc_host_model.word(OFC_ADDR_EXEC, 16'h0002, 1'b1);
        i_ofc_host_model.idle();
        chk({point_forced, point_status}, 16'h009a);
        i_ofc_host_model.word(OFC_ADDR_EXEC, OFC_EXEC_GO, 1'b1);
        i_ofc_host_model.idle();
        chk({point_forced, point_status}, 16'h049e);
        rdc(OFC_ADDR_EXEC, OFC_EXEC_GO);
        $display("end of test: separate execute");
        @(negedge sys_clk);
        rstn = 1'b0;
        repeat (2) @(negedge sys_clk);
        rstn = 1'b1;
        chk({nv_forced_out, point_status}, 16'h009a);
        @(negedge sys_clk);
        nv_load = 1'b1;
        @(negedge sys_clk);
        nv_load = 1'b0;
        chk({point_forced, relay_drive}, 16'h8421);
        chk({nv_value_out, point_status}, 16'h001a);
        $display("end of test: restore from store");
        conclude();
    end
endmodule
`default_nettype wire
